// ==== bench/press_encoder_model.sv ====
// Behavioural press position encoder and group acknowledge source
`timescale 1ns/10ps
module press_encoder_model #(
   parameter int POS_W = 16
) (
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic [1:0]       dir_cmd,
   input  wire press_motion_pkg::zone_t zone_cmd,
   input  wire logic             ack_cmd,
   output logic                  standstill,
   output logic                  move_cw,
   output logic                  move_ccw,
   output press_motion_pkg::zone_t zones,
   output logic [POS_W-1:0]      position,
   output logic                  group_error_acknowledge
);
   import press_motion_pkg::*;

   // Direction 1 turns clockwise, 2 counter-clockwise, 0 holds still
   assign move_cw                 = (dir_cmd == 2'd1);
   assign move_ccw                = (dir_cmd == 2'd2);
   assign standstill              = !move_cw && !move_ccw;
   assign zones                   = zone_cmd;
   assign group_error_acknowledge = ack_cmd;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         position <= POS_W'(16'h0100);
      end else if (move_cw) begin
         position <= position + 1'b1;
      end else if (move_ccw) begin
         position <= position - 1'b1;
      end
   end
endmodule : press_encoder_model

// ==== bench/press_motion_monitor_tb.sv ====
// Self-checking bench for the press motion monitor
`timescale 1ns/10ps
module press_motion_monitor_tb;
   import press_motion_pkg::*;

   localparam int    PW     = 16;
   localparam zone_t Z_NONE = 7'h00;
   localparam zone_t Z_LEFT = 7'h40;
   localparam zone_t Z_RGT  = 7'h20;
   localparam zone_t Z_TDC  = 7'h10;
   localparam zone_t Z_TC1  = 7'h08;
   localparam zone_t Z_TC1O = 7'h04;
   localparam zone_t Z_TC2O = 7'h01;

   logic          core_clk = 1'b0;
   logic          rst = 1'b1;
   logic          run_enable = 1'b0;
   logic          pendulum_mode = 1'b0;
   logic          reset_in = 1'b0;
   logic [1:0]    dir_cmd = 2'd0;
   zone_t         zone_cmd = Z_NONE;
   logic          ack_cmd = 1'b0;
   logic          standstill, move_cw, move_ccw, group_error_acknowledge;
   zone_t         zones, zone_out;
   logic [PW-1:0] position, diag_actual_pos, diag_last_pos;
   logic          monitor_ok, error_out;
   logic [7:0]    state_code;
   logic [15:0]   diag_code;
   int            fails = 0;
   int            checked = 0;

   always #10 core_clk = ~core_clk;

   press_encoder_model #(.POS_W(PW)) far_side (
      .core_clk(core_clk), .rst(rst), .dir_cmd(dir_cmd), .zone_cmd(zone_cmd),
      .ack_cmd(ack_cmd), .standstill(standstill), .move_cw(move_cw),
      .move_ccw(move_ccw), .zones(zones), .position(position),
      .group_error_acknowledge(group_error_acknowledge));

   press_motion_monitor #(.POS_W(PW)) uut (
      .core_clk(core_clk), .rst(rst), .run_enable(run_enable),
      .pendulum_mode(pendulum_mode), .reset_in(reset_in),
      .group_error_acknowledge(group_error_acknowledge), .standstill(standstill),
      .move_cw(move_cw), .move_ccw(move_ccw), .zones(zones), .position(position),
      .monitor_ok(monitor_ok), .error_out(error_out), .zone_out(zone_out),
      .state_code(state_code), .diag_code(diag_code),
      .diag_actual_pos(diag_actual_pos), .diag_last_pos(diag_last_pos));

   task automatic chk_flag(input string what, input logic exp, input logic got);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %s expected %b seen %b", what, exp, got);
      end
   endtask : chk_flag

   task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_val

   // Bounded wait for a state, then judge it
   task automatic expect_code(input logic [7:0] code);
      for (int i = 0; i < 8; i++) begin
         @(posedge core_clk);
         #1;
         if (state_code === code) break;
      end
      chk_val("state_code", {24'h0, code}, {24'h0, state_code});
   endtask : expect_code

   task automatic outs_quiet(input logic err);
      chk_flag("monitor_ok", 1'b0, monitor_ok);
      chk_flag("error_out", err, error_out);
      chk_val("zone_out", 32'h0, {25'h0, zone_out});
   endtask : outs_quiet

   task automatic t_reset;
      chk_val("state_code", 32'h02, {24'h0, state_code});
      outs_quiet(1'b0);
      $display("test reset done");
   endtask : t_reset

   task automatic t_start_run;
      @(posedge core_clk); run_enable <= 1'b1; reset_in <= 1'b1;
      expect_code(CODE_START);
      @(posedge core_clk); reset_in <= 1'b0;
      expect_code(CODE_RUN);
      chk_flag("monitor_ok", 1'b1, monitor_ok);
      @(posedge core_clk); zone_cmd <= Z_LEFT;
      repeat (2) @(posedge core_clk);
      #1;
      chk_val("zone_out", {25'h0, Z_LEFT}, {25'h0, zone_out});
      @(posedge core_clk); zone_cmd <= Z_NONE;
      $display("test start_run done");
   endtask : t_start_run

   task automatic t_eccentric;
      @(posedge core_clk); zone_cmd <= Z_TDC;
      expect_code(CODE_M_STOP);
      @(posedge core_clk); reset_in <= 1'b1;
      expect_code(CODE_M_START);
      @(posedge core_clk); reset_in <= 1'b0; dir_cmd <= 2'd1; zone_cmd <= Z_NONE;
      expect_code(CODE_M_DOWN);
      @(posedge core_clk); zone_cmd <= Z_LEFT;
      expect_code(CODE_M_UP);
      chk_flag("monitor_ok", 1'b1, monitor_ok);
      @(posedge core_clk); zone_cmd <= Z_TDC;
      expect_code(CODE_M_TDC);
      @(posedge core_clk); dir_cmd <= 2'd0;
      expect_code(CODE_M_STOP);
      @(posedge core_clk); dir_cmd <= 2'd1;
      expect_code(CODE_SAFE);
      outs_quiet(1'b0);
      @(posedge core_clk); dir_cmd <= 2'd0; reset_in <= 1'b1;
      expect_code(CODE_START);
      @(posedge core_clk); reset_in <= 1'b0; zone_cmd <= Z_NONE;
      expect_code(CODE_RUN);
      $display("test eccentric done");
   endtask : t_eccentric

   task automatic t_pendulum;
      @(posedge core_clk); pendulum_mode <= 1'b1; dir_cmd <= 2'd1;
      expect_code(CODE_CW_DOWN);
      @(posedge core_clk); zone_cmd <= Z_LEFT;
      expect_code(CODE_CW_UP);
      @(posedge core_clk); zone_cmd <= Z_TC1O;
      expect_code(CODE_TC1_UP);
      @(posedge core_clk); dir_cmd <= 2'd0;
      expect_code(CODE_TC1_STOP);
      @(posedge core_clk); reset_in <= 1'b1;
      expect_code(CODE_TC1_START);
      @(posedge core_clk); reset_in <= 1'b0; dir_cmd <= 2'd2; zone_cmd <= Z_NONE;
      expect_code(CODE_CCW_DOWN);
      @(posedge core_clk); zone_cmd <= Z_RGT;
      expect_code(CODE_CCW_UP);
      @(posedge core_clk); zone_cmd <= Z_TC2O;
      expect_code(CODE_TC2_UP);
      @(posedge core_clk); dir_cmd <= 2'd0;
      expect_code(CODE_TC2_STOP);
      @(posedge core_clk); reset_in <= 1'b1;
      expect_code(CODE_TC2_START);
      @(posedge core_clk); reset_in <= 1'b0; dir_cmd <= 2'd1; zone_cmd <= Z_TC1;
      expect_code(CODE_CW_DOWN);
      expect_code(CODE_TC1_UP);
      $display("test pendulum done");
   endtask : t_pendulum

   task automatic t_error;
      @(posedge core_clk); dir_cmd <= 2'd0; reset_in <= 1'b1;
      expect_code(CODE_TC1_STOP);
      expect_code(CODE_TC1_START);
      @(posedge core_clk); reset_in <= 1'b0; dir_cmd <= 2'd2; zone_cmd <= Z_NONE;
      expect_code(CODE_CCW_DOWN);
      @(posedge core_clk); dir_cmd <= 2'd0; reset_in <= 1'b1; zone_cmd <= Z_TC2O;
      expect_code(CODE_TC2_UP);
      expect_code(CODE_TC2_STOP);
      expect_code(CODE_TC2_START);
      @(posedge core_clk); reset_in <= 1'b0; dir_cmd <= 2'd1; zone_cmd <= Z_NONE;
      expect_code(CODE_CW_DOWN);
      @(posedge core_clk); zone_cmd <= Z_LEFT;
      expect_code(CODE_CW_UP);
      @(posedge core_clk); dir_cmd <= 2'd2;
      expect_code(CODE_ERROR);
      outs_quiet(1'b1);
      chk_val("diag_code", {16'h0, DIAG_CCW_IN_CW}, {16'h0, diag_code});
      chk_val("diag_actual_pos", {16'h0, position + 16'h1}, {16'h0, diag_actual_pos});
      chk_val("diag_last_pos", {16'h0, position}, {16'h0, diag_last_pos});
      @(posedge core_clk); dir_cmd <= 2'd0; ack_cmd <= 1'b1;
      expect_code(CODE_RESET);
      chk_flag("error_out", 1'b0, error_out);
      @(posedge core_clk); ack_cmd <= 1'b0;
      expect_code(CODE_WAIT_RST);
      @(posedge core_clk); reset_in <= 1'b1;
      expect_code(CODE_START);
      chk_val("diag_code", 32'h0, {16'h0, diag_code});
      @(posedge core_clk); reset_in <= 1'b0;
      expect_code(CODE_RUN);
      $display("test error done");
   endtask : t_error

   task automatic t_disable;
      @(posedge core_clk); run_enable <= 1'b0;
      expect_code(CODE_STOP);
      outs_quiet(1'b0);
      $display("test disable done");
   endtask : t_disable

   task automatic give_verdict;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : give_verdict

   initial begin
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      #1;
      t_reset();
      t_start_run();
      t_eccentric();
      t_pendulum();
      t_error();
      t_disable();
      give_verdict();
   end

   initial begin
      repeat (3000) @(posedge core_clk);
      fails++;
      give_verdict();
   end
endmodule : press_motion_monitor_tb

// ==== rtl/press_motion_monitor.sv ====
// Press stroke motion monitor: eccentric and pendulum state machine
// Operation
// - Run: monitor_ok high, zone outputs follow position
// - Stop: monitor_ok, error and zone outputs low
// - Motion deviation enters safe, outputs low
// - Error: error output only
// - Error to reset on acknowledge, nothing pending
// - Stop left with reset high gives start
// - Reset to wait-for-reset when reset, acknowledge low
// - Eccentric standstill in top centre is move-stop
// - Move-stop plus reset gives move-start
// - Move-start, reset low gives move-down
// - Move-down, left zone gives move-up
// - Move-up, top max zone gives move-top
// - Clockwise down start gives clockwise move-down
// - Clockwise down, left zone gives clockwise up
// - First centre or overrun gives up-first-centre
// - Standstill there gives stop-first-centre
// - Reset there gives start-first-centre
// - Counter-clockwise down start gives its move-down
// - Right zone gives counter-clockwise up
// - Second centre or overrun gives up-second-centre
// - Standstill stops, then reset starts, second centre
// - Current state code is output
// - Reverse move in clockwise up is error
`timescale 1ns/10ps
module press_motion_monitor #(
   parameter int POS_W = press_motion_pkg::POS_W_DEF
) (
   input  wire logic                    core_clk,
   input  wire logic                    rst,
   input  wire logic                    run_enable,
   input  wire logic                    pendulum_mode,
   input  wire logic                    reset_in,
   input  wire logic                    group_error_acknowledge,
   input  wire logic                    standstill,
   input  wire logic                    move_cw,
   input  wire logic                    move_ccw,
   input  wire press_motion_pkg::zone_t zones,
   input  wire logic [POS_W-1:0]        position,
   output logic                         monitor_ok,
   output logic                         error_out,
   output press_motion_pkg::zone_t      zone_out,
   output logic [7:0]                   state_code,
   output logic [15:0]                  diag_code,
   output logic [POS_W-1:0]             diag_actual_pos,
   output logic [POS_W-1:0]             diag_last_pos
);
   import press_motion_pkg::*;

   if (POS_W < 2 || POS_W > 32) begin : g_bad_width
      $error("POS_W must be 2 to 32");
   end

   state_t           state_q;
   state_t           state_d;
   logic [POS_W-1:0] last_pos_q;
   logic             rev_cw;
   logic             rev_ccw;

   assign rev_cw  = (state_q == S_CW_UP) && move_ccw;
   assign rev_ccw = (state_q == S_CCW_UP) && move_cw;

   always_comb begin
      state_d = state_q;
      case (state_q)
         S_STOP: begin
            if (run_enable) begin
               state_d = reset_in ? S_START : S_RUN;
            end
         end
         S_START: begin
            if (!reset_in) begin
               state_d = S_RUN;
            end
         end
         S_RUN: begin
            if (!pendulum_mode && standstill && zones.tdc_max) begin
               state_d = S_M_STOP;
            end else if (pendulum_mode && move_cw) begin
               state_d = S_CW_DOWN;
            end else if (pendulum_mode && move_ccw) begin
               state_d = S_CCW_DOWN;
            end
         end
         S_M_STOP: begin
            if (reset_in) begin
               state_d = S_M_START;
            end else if (!standstill) begin
               state_d = S_SAFE;
            end
         end
         S_M_START: begin
            if (!reset_in) begin
               state_d = S_M_DOWN;
            end
         end
         S_M_DOWN: begin
            if (zones.left) begin
               state_d = S_M_UP;
            end
         end
         S_M_UP: begin
            if (zones.tdc_max) begin
               state_d = S_M_TDC;
            end
         end
         S_M_TDC: begin
            if (standstill) begin
               state_d = S_M_STOP;
            end
         end
         S_CW_DOWN, S_CW_UP: begin
            if (rev_cw) begin
               state_d = S_ERROR;
            end else if (zones.tc1 || zones.tc1_over) begin
               state_d = S_TC1_UP;
            end else if (state_q == S_CW_DOWN && zones.left) begin
               state_d = S_CW_UP;
            end
         end
         S_TC1_UP: begin
            if (standstill) begin
               state_d = S_TC1_STOP;
            end
         end
         S_TC1_STOP: begin
            if (reset_in) begin
               state_d = S_TC1_START;
            end else if (!standstill) begin
               state_d = S_SAFE;
            end
         end
         S_TC1_START: begin
            if (move_ccw) begin
               state_d = S_CCW_DOWN;
            end
         end
         S_CCW_DOWN, S_CCW_UP: begin
            if (rev_ccw) begin
               state_d = S_ERROR;
            end else if (zones.tc2 || zones.tc2_over) begin
               state_d = S_TC2_UP;
            end else if (state_q == S_CCW_DOWN && zones.right) begin
               state_d = S_CCW_UP;
            end
         end
         S_TC2_UP: begin
            if (standstill) begin
               state_d = S_TC2_STOP;
            end
         end
         S_TC2_STOP: begin
            if (reset_in) begin
               state_d = S_TC2_START;
            end else if (!standstill) begin
               state_d = S_SAFE;
            end
         end
         S_TC2_START: begin
            if (move_cw) begin
               state_d = S_CW_DOWN;
            end
         end
         S_SAFE: begin
            if (reset_in && standstill) begin
               state_d = S_START;
            end
         end
         S_ERROR: begin
            if (group_error_acknowledge && standstill) begin
               state_d = S_RESET;
            end
         end
         S_RESET: begin
            if (!reset_in && !group_error_acknowledge) begin
               state_d = S_WAIT_RST;
            end
         end
         S_WAIT_RST: begin
            if (reset_in) begin
               state_d = S_START;
            end
         end
         default: state_d = S_STOP;
      endcase
      // Disable wins except in error and in reset while the error is being cleared
      if (!run_enable && !(state_q inside {S_ERROR, S_RESET})) begin
         state_d = S_STOP;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_q    <= S_STOP;
         state_code <= CODE_STOP;
      end else begin
         state_q    <= state_d;
         state_code <= code_of(state_d);
      end
   end

   // Outputs registered from the next state so they match state_q
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         monitor_ok <= 1'b0;
         error_out  <= 1'b0;
         zone_out   <= '0;
      end else begin
         monitor_ok <= is_active(state_d);
         error_out  <= (state_d == S_ERROR);
         zone_out   <= is_active(state_d) ? zones : '0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         last_pos_q <= '0;
      end else begin
         last_pos_q <= position;
      end
   end

   // Diagnostics captured on entry to error; diag_code cleared in reset, both positions kept
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         diag_code       <= DIAG_NONE;
         diag_actual_pos <= '0;
         diag_last_pos   <= '0;
      end else if (state_q != S_ERROR && state_d == S_ERROR) begin
         diag_code       <= rev_cw ? DIAG_CCW_IN_CW : DIAG_CW_IN_CCW;
         diag_actual_pos <= position;
         diag_last_pos   <= last_pos_q;
      end else if (state_q == S_RESET) begin
         diag_code       <= DIAG_NONE;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence s_cw_rev;
      state_q == S_CW_UP && run_enable && move_ccw;
   endsequence
   sequence s_err_entry;
      state_q == S_ERROR && diag_code == DIAG_CCW_IN_CW;
   endsequence

   property p_run_ok;
      state_q == S_RUN |-> monitor_ok && !error_out && zone_out == $past(zones);
   endproperty
   a_run_ok: assert property (p_run_ok) else $error("run outputs wrong");

   property p_stop_low;
      state_q == S_STOP |-> !monitor_ok && !error_out && zone_out == '0;
   endproperty
   a_stop_low: assert property (p_stop_low) else $error("stop outputs not low");

   property p_safe;
      state_q == S_M_STOP && run_enable && !reset_in && !standstill
         |=> state_q == S_SAFE && !monitor_ok && zone_out == '0;
   endproperty
   a_safe: assert property (p_safe) else $error("deviation not safe");

   property p_error_out;
      error_out == (state_q == S_ERROR) && !(error_out && monitor_ok);
   endproperty
   a_error_out: assert property (p_error_out) else $error("error output wrong");

   property p_reset;
      state_q == S_ERROR && group_error_acknowledge && standstill |=> state_q == S_RESET;
   endproperty
   a_reset: assert property (p_reset) else $error("ack not taken");

   property p_start;
      state_q == S_STOP && run_enable && reset_in |=> state_q == S_START;
   endproperty
   a_start: assert property (p_start) else $error("start not entered");

   property p_wait;
      state_q == S_RESET && !reset_in && !group_error_acknowledge |=> state_q == S_WAIT_RST;
   endproperty
   a_wait: assert property (p_wait) else $error("wait not entered");

   property p_ecc_chain;
      state_q == S_M_STOP && run_enable && reset_in ##1 run_enable && !reset_in
         |=> state_q == S_M_DOWN;
   endproperty
   a_ecc_chain: assert property (p_ecc_chain) else $error("eccentric start wrong");

   property p_tc1;
      (state_q inside {S_CW_DOWN, S_CW_UP}) && run_enable && !move_ccw
         && (zones.tc1 || zones.tc1_over) |=> state_q == S_TC1_UP;
   endproperty
   a_tc1: assert property (p_tc1) else $error("first centre missed");

   property p_tc2_stop;
      state_q == S_TC2_UP && run_enable && standstill ##1 run_enable && reset_in
         |=> state_q == S_TC2_START;
   endproperty
   a_tc2_stop: assert property (p_tc2_stop) else $error("second centre stop wrong");

   property p_rev;
      s_cw_rev |=> s_err_entry and (diag_actual_pos == $past(position)
         && diag_last_pos == $past(last_pos_q));
   endproperty
   a_rev: assert property (p_rev) else $error("reverse move not flagged");

   property p_code;
      state_code == code_of(state_q);
   endproperty
   a_code: assert property (p_code) else $error("state code stale");

   sequence s_down_left;
      state_q == S_M_DOWN && run_enable && zones.left;
   endsequence
   sequence s_tc1_halt;
      state_q == S_TC1_UP && run_enable && standstill;
   endsequence

   property p_ecc_park;
      state_q == S_RUN && run_enable && !pendulum_mode && standstill && zones.tdc_max
         |=> state_q == S_M_STOP;
   endproperty
   a_ecc_park: assert property (p_ecc_park) else $error("move-stop not entered");

   property p_ecc_up;
      s_down_left |=> state_q == S_M_UP;
   endproperty
   a_ecc_up: assert property (p_ecc_up) else $error("move-up not entered");

   property p_ecc_top;
      state_q == S_M_UP && run_enable && zones.tdc_max |=> state_q == S_M_TDC;
   endproperty
   a_ecc_top: assert property (p_ecc_top) else $error("move-top not entered");

   property p_cw_start;
      state_q == S_RUN && run_enable && pendulum_mode && move_cw |=> state_q == S_CW_DOWN;
   endproperty
   a_cw_start: assert property (p_cw_start) else $error("clockwise start missed");

   property p_cw_up;
      state_q == S_CW_DOWN && run_enable && zones.left && !zones.tc1 && !zones.tc1_over
         |=> state_q == S_CW_UP;
   endproperty
   a_cw_up: assert property (p_cw_up) else $error("clockwise up missed");

   property p_tc1_stop;
      s_tc1_halt ##1 run_enable && reset_in |=> state_q == S_TC1_START;
   endproperty
   a_tc1_stop: assert property (p_tc1_stop) else $error("first centre stop wrong");

   property p_ccw_up;
      state_q == S_CCW_DOWN && run_enable && zones.right && !zones.tc2 && !zones.tc2_over
         |=> state_q == S_CCW_UP;
   endproperty
   a_ccw_up: assert property (p_ccw_up) else $error("counter-clockwise up missed");

   property p_tc2;
      (state_q inside {S_CCW_DOWN, S_CCW_UP}) && run_enable && !move_cw
         && (zones.tc2 || zones.tc2_over) |=> state_q == S_TC2_UP;
   endproperty
   a_tc2: assert property (p_tc2) else $error("second centre missed");

endmodule : press_motion_monitor

// ==== rtl/press_motion_pkg.sv ====
// Constants, types and state decode for the press motion monitor
package press_motion_pkg;

   localparam logic [7:0]  CODE_RUN        = 8'h01;
   localparam logic [7:0]  CODE_STOP       = 8'h02;
   localparam logic [7:0]  CODE_SAFE       = 8'h03;
   localparam logic [7:0]  CODE_ERROR      = 8'h04;
   localparam logic [7:0]  CODE_RESET      = 8'h05;
   localparam logic [7:0]  CODE_START      = 8'h06;
   localparam logic [7:0]  CODE_WAIT_RST   = 8'h0f;
   localparam logic [7:0]  CODE_M_STOP     = 8'h10;
   localparam logic [7:0]  CODE_M_START    = 8'h11;
   localparam logic [7:0]  CODE_M_DOWN     = 8'h12;
   localparam logic [7:0]  CODE_M_UP       = 8'h13;
   localparam logic [7:0]  CODE_M_TDC      = 8'h14;
   localparam logic [7:0]  CODE_CW_DOWN    = 8'h20;
   localparam logic [7:0]  CODE_CW_UP      = 8'h21;
   localparam logic [7:0]  CODE_TC1_UP     = 8'h22;
   localparam logic [7:0]  CODE_TC1_STOP   = 8'h23;
   localparam logic [7:0]  CODE_TC1_START  = 8'h24;
   localparam logic [7:0]  CODE_CCW_DOWN   = 8'h25;
   localparam logic [7:0]  CODE_CCW_UP     = 8'h26;
   localparam logic [7:0]  CODE_TC2_UP     = 8'h27;
   localparam logic [7:0]  CODE_TC2_STOP   = 8'h28;
   localparam logic [7:0]  CODE_TC2_START  = 8'h29;

   localparam logic [15:0] DIAG_NONE       = 16'h0000;
   localparam logic [15:0] DIAG_CCW_IN_CW  = 16'h4022;
   localparam logic [15:0] DIAG_CW_IN_CCW  = 16'h4023;

   localparam int          POS_W_DEF       = 32;

   typedef enum logic [4:0] {
      S_STOP      = 5'h00, S_START     = 5'h01, S_RUN       = 5'h03,
      S_M_STOP    = 5'h02, S_M_START   = 5'h06, S_M_DOWN    = 5'h07,
      S_M_UP      = 5'h05, S_M_TDC     = 5'h04, S_CW_DOWN   = 5'h0c,
      S_CW_UP     = 5'h0d, S_TC1_UP    = 5'h0f, S_TC1_STOP  = 5'h0e,
      S_TC1_START = 5'h0a, S_CCW_DOWN  = 5'h0b, S_CCW_UP    = 5'h09,
      S_TC2_UP    = 5'h08, S_TC2_STOP  = 5'h18, S_TC2_START = 5'h19,
      S_SAFE      = 5'h1b, S_ERROR     = 5'h1a, S_RESET     = 5'h1e,
      S_WAIT_RST  = 5'h1f
   } state_t;

   typedef struct packed {
      logic left;
      logic right;
      logic tdc_max;
      logic tc1;
      logic tc1_over;
      logic tc2;
      logic tc2_over;
   } zone_t;

   function automatic logic [7:0] code_of(input state_t s);
      case (s)
         S_RUN:       code_of = CODE_RUN;
         S_STOP:      code_of = CODE_STOP;
         S_SAFE:      code_of = CODE_SAFE;
         S_ERROR:     code_of = CODE_ERROR;
         S_RESET:     code_of = CODE_RESET;
         S_START:     code_of = CODE_START;
         S_WAIT_RST:  code_of = CODE_WAIT_RST;
         S_M_STOP:    code_of = CODE_M_STOP;
         S_M_START:   code_of = CODE_M_START;
         S_M_DOWN:    code_of = CODE_M_DOWN;
         S_M_UP:      code_of = CODE_M_UP;
         S_M_TDC:     code_of = CODE_M_TDC;
         S_CW_DOWN:   code_of = CODE_CW_DOWN;
         S_CW_UP:     code_of = CODE_CW_UP;
         S_TC1_UP:    code_of = CODE_TC1_UP;
         S_TC1_STOP:  code_of = CODE_TC1_STOP;
         S_TC1_START: code_of = CODE_TC1_START;
         S_CCW_DOWN:  code_of = CODE_CCW_DOWN;
         S_CCW_UP:    code_of = CODE_CCW_UP;
         S_TC2_UP:    code_of = CODE_TC2_UP;
         S_TC2_STOP:  code_of = CODE_TC2_STOP;
         default:     code_of = CODE_TC2_START;
      endcase
   endfunction : code_of

   // Active states: monitor healthy, outputs follow position
   function automatic logic is_active(input state_t s);
      is_active = !(s inside {S_STOP, S_SAFE, S_ERROR, S_RESET, S_START, S_WAIT_RST});
   endfunction : is_active

endpackage : press_motion_pkg
